/* File: logic/dmc_pkg.sv */
// =====================================================================
// Shared constants and types for the direct-mapped split cache.
// =====================================================================
package dmc_pkg;

  // Geometry of the arrays.
  localparam int unsigned LINE_COUNT = 512;
  localparam int unsigned WORD_COUNT = 2048;
  localparam int unsigned TAG_IDX_W  = 9;
  localparam int unsigned DATA_IDX_W = 11;
  localparam int unsigned TAG_W      = 20;
  localparam int unsigned TAG_ENTRY_W = TAG_W + 1;
  localparam int unsigned LINE_W     = 28;

  // Address field positions.
  localparam int unsigned ADDR_TAG_HI    = 31;
  localparam int unsigned ADDR_TAG_LO    = 12;
  localparam int unsigned ADDR_IDX_HI    = 12;
  localparam int unsigned ADDR_IDX_HI_SP = 11;
  localparam int unsigned ADDR_LINE_LO   = 4;
  localparam int unsigned ADDR_WORD_HI   = 3;
  localparam int unsigned ADDR_WORD_LO   = 2;
  localparam int unsigned TAG_VALID_BIT  = 20;

  // Control register layout: enable in bit 0, configuration in bits 2:1.
  localparam int unsigned CCR_W        = 3;
  localparam int unsigned CCR_EN_BIT   = 0;
  localparam int unsigned CCR_MODE_HI  = 2;
  localparam int unsigned CCR_MODE_LO  = 1;
  localparam logic [2:0]  CCR_RESET    = 3'h0;
  localparam logic [1:0]  MODE_INSTR   = 2'h0;
  localparam logic [1:0]  MODE_DATA    = 2'h1;
  localparam logic [1:0]  MODE_SPLIT   = 2'h2;

  // Line fill sequencing and the invalidate walk.
  localparam logic [1:0]  BEAT_FIRST   = 2'h0;
  localparam logic [1:0]  BEAT_LAST    = 2'h3;
  localparam logic [1:0]  BEAT_STEP    = 2'h1;
  localparam logic [8:0]  WALK_FIRST   = 9'h000;
  localparam logic [8:0]  WALK_LAST    = 9'h1FF;
  localparam logic [8:0]  WALK_STEP    = 9'h001;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FILL,
    ST_SINGLE,
    ST_INVAL
  } dmc_state_type;

endpackage : dmc_pkg

/* File: logic/dmc_mem.sv */
`timescale 1ns/1ps
// =====================================================================
// Simple dual-port array with a registered read port.
// =====================================================================
module dmc_mem #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 2048,
  parameter int unsigned AW    = 11
) (
  input  wire logic             clock,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data
);

  logic [WIDTH-1:0] store [DEPTH];

  // Contents are not reset, so a reset leaves the arrays as they were.
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
  end

  // A read in the cycle of a write to the same entry returns the old word.
  always_ff @(posedge clock)
  begin
    if (rd_en)
    begin
      rd_data_q <= store[rd_addr];
    end
  end

endmodule : dmc_mem

/* File: logic/dmc_cache.sv */
`timescale 1ns/1ps
module dmc_cache (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ccr_write,
  input  wire logic [2:0]  ccr_wdata,
  input  wire logic        invalidate_all_lines,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic        req_instr,
  input  wire logic        req_sram,
  output logic             req_ready_q,
  output logic             resp_valid_q,
  output logic             resp_retry_q,
  output logic [31:0]      resp_data_q,
  output logic [2:0]       cache_control_register_q,
  output logic             ext_req_q,
  output logic             ext_line_q,
  output logic [31:0]      ext_addr_q,
  input  wire logic        ext_ack,
  input  wire logic [31:0] ext_rdata
);

  // ===================================================================
  // Configuration and indexing
  // ===================================================================
  logic                           split;
  logic                           accept;
  logic                           s1_valid_q;
  logic [31:0]                    s1_addr_q;
  logic                           s1_instr_q;
  logic                           s1_sram_q;
  logic                           s1_en;
  logic [dmc_pkg::TAG_ENTRY_W-1:0] tag_rd;
  logic [31:0]                    data_rd;
  logic                           tag_we;
  logic [dmc_pkg::TAG_IDX_W-1:0]  tag_wa;
  logic [dmc_pkg::TAG_ENTRY_W-1:0] tag_wd;
  logic                           data_we;
  logic [dmc_pkg::DATA_IDX_W-1:0] data_wa;
  dmc_pkg::dmc_state_type         state_q;
  logic [1:0]                     beat_q;
  logic [1:0]                     crit_q;
  logic [27:0]                    fill_line_q;
  logic                           fill_instr_q;
  logic [8:0]                     walk_q;
  logic                           inval_pend_q;
  logic                           in_flight_q;
  logic [27:0]                    buf_line_q  [2];
  logic [3:0]                     buf_vld_q   [2];
  logic [31:0]                    buf_word_q  [2][4];

  assign split = cache_control_register_q[dmc_pkg::CCR_MODE_HI:dmc_pkg::CCR_MODE_LO] == dmc_pkg::MODE_SPLIT;

  // Debug and core fetches share one port, so nothing here tells them apart.
  assign accept = req_valid && req_ready_q;

  function automatic logic type_on(input logic [2:0] ccr, input logic instr);
    logic [1:0] mode;
    mode = ccr[dmc_pkg::CCR_MODE_HI:dmc_pkg::CCR_MODE_LO];
    type_on = ccr[dmc_pkg::CCR_EN_BIT] &&
              (mode == dmc_pkg::MODE_SPLIT || mode == (instr ? dmc_pkg::MODE_INSTR : dmc_pkg::MODE_DATA));
  endfunction : type_on

  function automatic logic [8:0] tag_index(input logic [31:0] a, input logic instr, input logic sp);
    tag_index = sp ? {instr, a[dmc_pkg::ADDR_IDX_HI_SP:dmc_pkg::ADDR_LINE_LO]}
                   : a[dmc_pkg::ADDR_IDX_HI:dmc_pkg::ADDR_LINE_LO];
  endfunction : tag_index

  function automatic logic [10:0] data_index(input logic [31:0] a, input logic instr, input logic sp);
    data_index = sp ? {instr, a[dmc_pkg::ADDR_IDX_HI_SP:dmc_pkg::ADDR_WORD_LO]}
                    : a[dmc_pkg::ADDR_IDX_HI:dmc_pkg::ADDR_WORD_LO];
  endfunction : data_index

  // Control register: cleared by reset, loaded by the configuration strobe.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cache_control_register_q <= dmc_pkg::CCR_RESET;
    else if (ccr_write)
      cache_control_register_q <= ccr_wdata;
  end

  // ===================================================================
  // Arrays, read in parallel on the accepted request
  // ===================================================================
  dmc_mem #(.WIDTH(dmc_pkg::TAG_ENTRY_W), .DEPTH(dmc_pkg::LINE_COUNT), .AW(dmc_pkg::TAG_IDX_W)) u_tag (
    .clock     (clock),
    .rd_en     (accept),
    .rd_addr   (tag_index(req_addr, req_instr, split)),
    .rd_data_q (tag_rd),
    .wr_en     (tag_we),
    .wr_addr   (tag_wa),
    .wr_data   (tag_wd)
  );

  dmc_mem #(.WIDTH(32), .DEPTH(dmc_pkg::WORD_COUNT), .AW(dmc_pkg::DATA_IDX_W)) u_data (
    .clock     (clock),
    .rd_en     (accept),
    .rd_addr   (data_index(req_addr, req_instr, split)),
    .rd_data_q (data_rd),
    .wr_en     (data_we),
    .wr_addr   (data_wa),
    .wr_data   (ext_rdata)
  );

  // Stage one holds the request while the array outputs settle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_valid_q <= 1'b0;
      s1_addr_q  <= 32'h0000_0000;
      s1_instr_q <= 1'b0;
      s1_sram_q  <= 1'b0;
    end
    else
    begin
      s1_valid_q <= accept;
      if (accept)
      begin
        s1_addr_q  <= req_addr;
        s1_instr_q <= req_instr;
        s1_sram_q  <= req_sram;
      end
    end
  end

  // ===================================================================
  // Hit detection
  // ===================================================================
  logic array_hit;
  logic buf_hit;
  logic s1_hit;
  logic s1_miss;
  logic [1:0] s1_word;
  logic start_fill;
  logic start_single;

  assign s1_en     = type_on(cache_control_register_q, s1_instr_q);
  assign s1_word   = s1_addr_q[dmc_pkg::ADDR_WORD_HI:dmc_pkg::ADDR_WORD_LO];
  assign array_hit = s1_en && tag_rd[dmc_pkg::TAG_VALID_BIT] &&
                     (split ? tag_rd[19:0] == s1_addr_q[dmc_pkg::ADDR_TAG_HI:dmc_pkg::ADDR_TAG_LO]
                            : tag_rd[19:1] == s1_addr_q[dmc_pkg::ADDR_TAG_HI:dmc_pkg::ADDR_TAG_LO+1]);
  assign buf_hit   = s1_en && buf_line_q[s1_instr_q] == s1_addr_q[31:dmc_pkg::ADDR_LINE_LO] &&
                     buf_vld_q[s1_instr_q][s1_word];
  assign s1_hit    = s1_valid_q && !s1_sram_q && (array_hit || buf_hit);
  assign s1_miss   = s1_valid_q && !s1_sram_q && !array_hit && !buf_hit;
  assign start_fill   = s1_miss && state_q == dmc_pkg::ST_IDLE && s1_en;
  assign start_single = s1_miss && state_q == dmc_pkg::ST_IDLE && !s1_en;

  // ===================================================================
  // Miss sequencer: line fill, single word bypass and invalidate walk
  // ===================================================================
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q      <= dmc_pkg::ST_IDLE;
      beat_q       <= dmc_pkg::BEAT_FIRST;
      crit_q       <= dmc_pkg::BEAT_FIRST;
      fill_line_q  <= 28'h000_0000;
      fill_instr_q <= 1'b0;
      walk_q       <= dmc_pkg::WALK_FIRST;
    end
    else
    begin
      case (state_q)
        dmc_pkg::ST_IDLE:
        begin
          if (start_fill)
          begin
            state_q      <= dmc_pkg::ST_FILL;
            beat_q       <= dmc_pkg::BEAT_FIRST;
            crit_q       <= s1_word;
            fill_line_q  <= s1_addr_q[31:dmc_pkg::ADDR_LINE_LO];
            fill_instr_q <= s1_instr_q;
          end
          else if (start_single)
            state_q <= dmc_pkg::ST_SINGLE;
          else if (inval_pend_q && !s1_valid_q && !in_flight_q)
          begin
            state_q <= dmc_pkg::ST_INVAL;
            walk_q  <= dmc_pkg::WALK_FIRST;
          end
        end
        dmc_pkg::ST_FILL:
        begin
          if (ext_ack)
          begin
            beat_q <= beat_q + dmc_pkg::BEAT_STEP;
            if (beat_q == dmc_pkg::BEAT_LAST)
              state_q <= dmc_pkg::ST_IDLE;
          end
        end
        dmc_pkg::ST_SINGLE:
        begin
          if (ext_ack)
            state_q <= dmc_pkg::ST_IDLE;
        end
        dmc_pkg::ST_INVAL:
        begin
          walk_q <= walk_q + dmc_pkg::WALK_STEP;
          if (walk_q == dmc_pkg::WALK_LAST)
            state_q <= dmc_pkg::ST_IDLE;
        end
        default:
          state_q <= dmc_pkg::ST_IDLE;
      endcase
    end
  end

  // The walk request is sticky; a new pulse in the cycle the walk starts wins.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      inval_pend_q <= 1'b0;
    else if (invalidate_all_lines)
      inval_pend_q <= 1'b1;
    else if (state_q == dmc_pkg::ST_INVAL)
      inval_pend_q <= 1'b0;
  end

  // The tag entry is cleared when a fill starts and set only on the last beat.
  always_comb
  begin
    tag_we = 1'b0;
    tag_wa = tag_index(s1_addr_q, s1_instr_q, split);
    tag_wd = {1'b0, s1_addr_q[dmc_pkg::ADDR_TAG_HI:dmc_pkg::ADDR_TAG_LO]};
    if (start_fill)
      tag_we = 1'b1;
    else if (state_q == dmc_pkg::ST_FILL && ext_ack && beat_q == dmc_pkg::BEAT_LAST)
    begin
      tag_we = 1'b1;
      tag_wa = tag_index({fill_line_q, 4'h0}, fill_instr_q, split);
      tag_wd = {1'b1, fill_line_q[27:8]};
    end
    else if (state_q == dmc_pkg::ST_INVAL)
    begin
      tag_we = 1'b1;
      tag_wa = walk_q;
      tag_wd = '0;
    end
  end

  assign data_we = state_q == dmc_pkg::ST_FILL && ext_ack;
  assign data_wa = data_index({fill_line_q, ext_addr_q[3:0]}, fill_instr_q, split);

  // External port: one beat per acknowledge, wrapping inside the line.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_req_q  <= 1'b0;
      ext_line_q <= 1'b0;
      ext_addr_q <= 32'h0000_0000;
    end
    else if (start_fill)
    begin
      ext_req_q  <= 1'b1;
      ext_line_q <= 1'b1;
      ext_addr_q <= {s1_addr_q[31:dmc_pkg::ADDR_LINE_LO], s1_word, 2'h0};
    end
    else if (start_single)
    begin
      ext_req_q  <= 1'b1;
      ext_line_q <= 1'b0;
      ext_addr_q <= {s1_addr_q[31:dmc_pkg::ADDR_WORD_LO], 2'h0};
    end
    else if (ext_req_q && ext_ack)
    begin
      if (state_q == dmc_pkg::ST_FILL && beat_q != dmc_pkg::BEAT_LAST)
        ext_addr_q[3:2] <= ext_addr_q[3:2] + dmc_pkg::BEAT_STEP;
      else
      begin
        ext_req_q  <= 1'b0;
        ext_line_q <= 1'b0;
      end
    end
  end

  // ===================================================================
  // Fill buffers, one per fetch type
  // ===================================================================
  for (genvar t = 0; t < 2; t++)
  begin : g_buf
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        buf_line_q[t] <= 28'h000_0000;
        buf_vld_q[t]  <= 4'h0;
      end
      else if (state_q == dmc_pkg::ST_INVAL)
        buf_vld_q[t] <= 4'h0;
      else if (start_fill && s1_instr_q == t)
      begin
        buf_line_q[t] <= s1_addr_q[31:dmc_pkg::ADDR_LINE_LO];
        buf_vld_q[t]  <= 4'h0;
      end
      else if (data_we && fill_instr_q == t)
        buf_vld_q[t][ext_addr_q[3:2]] <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
      if (data_we && fill_instr_q == t)
        buf_word_q[t][ext_addr_q[3:2]] <= ext_rdata;
    end
  end

  // ===================================================================
  // Answers to the requester
  // ===================================================================
  logic crit_beat;
  logic answer;

  assign crit_beat = ext_ack && ((state_q == dmc_pkg::ST_FILL && beat_q == dmc_pkg::BEAT_FIRST) ||
                                  state_q == dmc_pkg::ST_SINGLE);
  assign answer    = s1_hit || crit_beat || (s1_valid_q && s1_sram_q) ||
                     (s1_miss && state_q != dmc_pkg::ST_IDLE);

  // A second miss while the one external fetch is busy is told to retry.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid_q <= 1'b0;
      resp_retry_q <= 1'b0;
      resp_data_q  <= 32'h0000_0000;
    end
    else
    begin
      resp_valid_q <= s1_hit || crit_beat;
      resp_retry_q <= s1_miss && state_q != dmc_pkg::ST_IDLE;
      if (crit_beat)
        resp_data_q <= ext_rdata;
      else if (s1_hit)
        resp_data_q <= buf_hit ? buf_word_q[s1_instr_q][s1_word] : data_rd;
    end
  end

  // One request in flight; the bus is freed once it is answered.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      in_flight_q <= 1'b0;
    else if (accept)
      in_flight_q <= 1'b1;
    else if (answer)
      in_flight_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      req_ready_q <= 1'b0;
    else
      req_ready_q <= !accept && (!in_flight_q || answer) && !inval_pend_q && !invalidate_all_lines &&
                     state_q != dmc_pkg::ST_INVAL;
  end

  // ===================================================================
  // Checks
  // ===================================================================
  a_hit_answers: assert property (@(posedge clock) disable iff (!rst_n)
    s1_hit |=> resp_valid_q && !resp_retry_q) else $error("hit not answered next cycle");
  a_sram_discard: assert property (@(posedge clock) disable iff (!rst_n)
    s1_valid_q && s1_sram_q |=> !resp_valid_q && !resp_retry_q && !$rose(ext_req_q))
    else $error("sram access produced cache activity");
  a_one_fetch: assert property (@(posedge clock) disable iff (!rst_n)
    s1_miss && state_q != dmc_pkg::ST_IDLE |=> resp_retry_q && $stable(ext_line_q) || !ext_req_q)
    else $error("second miss not refused");
  a_wrap_order: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == dmc_pkg::ST_FILL && ext_ack && beat_q != dmc_pkg::BEAT_LAST
    |=> ext_addr_q[3:2] == $past(ext_addr_q[3:2]) + 2'h1 && ext_req_q) else $error("line beat order wrong");
  a_full_line_only: assert property (@(posedge clock) disable iff (!rst_n)
    tag_we && tag_wd[dmc_pkg::TAG_VALID_BIT] |-> state_q == dmc_pkg::ST_FILL && beat_q == dmc_pkg::BEAT_LAST)
    else $error("tag made valid before line complete");
  a_bypass_miss: assert property (@(posedge clock) disable iff (!rst_n)
    s1_miss && !s1_en && state_q == dmc_pkg::ST_IDLE |=> ext_req_q && !ext_line_q ##0 state_q == dmc_pkg::ST_SINGLE)
    else $error("disabled fetch not bypassed");
  a_critical_release: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == dmc_pkg::ST_FILL && ext_ack && beat_q == dmc_pkg::BEAT_FIRST
    |=> resp_valid_q && resp_data_q == $past(ext_rdata) && state_q == dmc_pkg::ST_FILL)
    else $error("critical word not returned early");
  a_walk_length: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == dmc_pkg::ST_INVAL && walk_q != dmc_pkg::WALK_LAST
    |=> state_q == dmc_pkg::ST_INVAL && walk_q == $past(walk_q) + 9'h001 && !req_ready_q)
    else $error("invalidate walk broken");

endmodule : dmc_cache

/* File: dv/dmc_ext_mem.sv */
`timescale 1ns/1ps
// =====================================================================
// External memory model answering the cache's beat requests.
// =====================================================================
module dmc_ext_mem (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ext_req_q,
  input  wire logic [31:0] ext_addr_q,
  input  wire logic [3:0]  wait_len,
  output logic             ext_ack,
  output logic [31:0]      ext_rdata
);
  logic [3:0] wait_q;

  // Ack one beat after wait_len idle cycles; the data bus churns between beats since nothing holds it.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_ack   <= 1'b0;
      ext_rdata <= 32'h0;
      wait_q    <= 4'h0;
    end
    else if (ext_req_q && !ext_ack && wait_q >= wait_len)
    begin
      ext_ack   <= 1'b1;
      ext_rdata <= {ext_addr_q[15:0], ~ext_addr_q[15:0]};
      wait_q    <= 4'h0;
    end
    else
    begin
      ext_ack   <= 1'b0;
      ext_rdata <= ~ext_rdata + 32'h1;
      wait_q    <= ext_req_q ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : dmc_ext_mem

/* File: dv/testbench.sv */
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the direct-mapped split cache.
// =====================================================================
module testbench;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        ccr_write = 1'b0;
  logic [2:0]  ccr_wdata = 3'h0;
  logic        inval = 1'b0;
  logic        req_valid = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic        req_instr = 1'b0;
  logic        req_sram = 1'b0;
  logic [3:0]  wait_len = 4'h2;
  logic        req_ready_q, resp_valid_q, resp_retry_q, ext_req_q, ext_line_q, ext_ack, line_seen;
  logic [31:0] resp_data_q, ext_addr_q, ext_rdata;
  logic [2:0]  ccr_q;
  logic [31:0] beats[$];
  int          mismatches = 0;
  int          tests_run = 0;

  dmc_cache i_dut (.clock(clock), .rst_n(rst_n), .ccr_write(ccr_write), .ccr_wdata(ccr_wdata),
    .invalidate_all_lines(inval), .req_valid(req_valid), .req_addr(req_addr), .req_instr(req_instr),
    .req_sram(req_sram), .req_ready_q(req_ready_q), .resp_valid_q(resp_valid_q),
    .resp_retry_q(resp_retry_q), .resp_data_q(resp_data_q), .cache_control_register_q(ccr_q),
    .ext_req_q(ext_req_q), .ext_line_q(ext_line_q), .ext_addr_q(ext_addr_q), .ext_ack(ext_ack),
    .ext_rdata(ext_rdata));
  dmc_ext_mem i_mem (.clock(clock), .rst_n(rst_n), .ext_req_q(ext_req_q), .ext_addr_q(ext_addr_q),
    .wait_len(wait_len), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

  // Clock at 10 MHz.
  always #50 clock = ~clock;

  // Record every accepted beat so burst order and count can be judged later.
  always @(posedge clock)
    if (ext_req_q === 1'b1 && ext_ack === 1'b1)
    begin
      beats.push_back(ext_addr_q);
      line_seen = ext_line_q;
    end

  // =====================================================================
  // Shared tasks.
  // =====================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Inputs always move 10 ns after the edge, well clear of sampling.
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask : step

  task automatic set_ccr(input logic [2:0] v);
    ccr_wdata = v;
    ccr_write = 1'b1;
    step(1);
    ccr_write = 1'b0;
    check(ccr_q, v, "control value");
  endtask : set_ccr

  // One fetch: held until taken, then the answer kind, data and latency are judged.
  task automatic access(input logic [31:0] a, input logic ins, input logic sram, input int ekind,
                        input int elat);
    logic taken;
    int   kind;
    int   lat;
    req_addr = a;
    req_instr = ins;
    req_sram = sram;
    req_valid = 1'b1;
    do
    begin
      taken = (req_ready_q === 1'b1);
      step(1);
    end
    while (!taken);
    req_valid = 1'b0;
    kind = 0;
    lat = 0;
    while (kind == 0 && lat < 40)
    begin
      step(1);
      lat++;
      if (resp_valid_q === 1'b1)
        kind = 1;
      else if (resp_retry_q === 1'b1)
        kind = 2;
    end
    check(kind, ekind, "answer kind");
    if (ekind == 1)
      check(resp_data_q, {a[15:0], ~a[15:0]}, "fetch data");
    if (elat > 0)
      check(lat, elat, "hit latency");
  endtask : access

  // Waits out the external fetch and judges its beats: count, kind and wrap order.
  task automatic fill_done(input logic [31:0] a, input int n, input logic line);
    int i;
    i = 0;
    while (ext_req_q === 1'b1 && i < 200)
    begin
      step(1);
      i++;
    end
    step(1);
    check(beats.size(), n, "beat count");
    if (n > 0)
      check(line_seen, line, "burst kind");
    for (i = 0; i < n; i++)
      check(beats[i], {a[31:4], a[3:2] + i[1:0], 2'b00}, "beat address");
    beats.delete();
  endtask : fill_done

  // =====================================================================
  // Scenarios.
  // =====================================================================
  task automatic t_invalidate();
    int n;
    inval = 1'b1;
    step(1);
    inval = 1'b0;
    step(1);
    n = 1;
    while (req_ready_q !== 1'b1 && n < 700)
    begin
      step(1);
      n++;
    end
    check(n >= 511 && n <= 530, 1'b1, "walk length");
    $display("test invalidate done");
  endtask : t_invalidate

  task automatic t_bypass();
    check(ccr_q, 3'h0, "control after reset");
    access(32'h0000_0104, 1'b1, 1'b0, 1, 0);
    fill_done(32'h0000_0104, 1, 1'b0);
    set_ccr(3'h1);
    access(32'h0000_0208, 1'b0, 1'b0, 1, 0);
    fill_done(32'h0000_0208, 1, 1'b0);
    access(32'h0000_0510, 1'b1, 1'b0, 1, 0);
    fill_done(32'h0000_0510, 4, 1'b1);
    access(32'h0000_0400, 1'b0, 1'b1, 0, 0);
    fill_done(32'h0000_0400, 0, 1'b0);
    set_ccr(3'h7);
    access(32'h0000_030C, 1'b1, 1'b0, 1, 0);
    fill_done(32'h0000_030C, 1, 1'b0);
    $display("test bypass done");
  endtask : t_bypass

  // Slow memory so later requests land while the line is still filling.
  task automatic t_data();
    set_ccr(3'h3);
    wait_len = 4'h6;
    access(32'h0001_2348, 1'b0, 1'b0, 1, 0);
    access(32'h0001_2348, 1'b0, 1'b0, 1, 1);
    access(32'h0003_0000, 1'b0, 1'b0, 2, 0);
    access(32'h0001_2100, 1'b0, 1'b1, 0, 0);
    fill_done(32'h0001_2348, 4, 1'b1);
    access(32'h0001_2344, 1'b0, 1'b0, 1, 1);
    access(32'h0001_4348, 1'b0, 1'b0, 1, 0);
    fill_done(32'h0001_4348, 4, 1'b1);
    access(32'h0001_234C, 1'b0, 1'b0, 1, 0);
    fill_done(32'h0001_234C, 4, 1'b1);
    $display("test data cache done");
  endtask : t_data

  // Prompt memory; both halves must hold the same index without clashing.
  task automatic t_split();
    t_invalidate();
    set_ccr(3'h5);
    wait_len = 4'h0;
    access(32'h0004_5670, 1'b1, 1'b0, 1, 0);
    fill_done(32'h0004_5670, 4, 1'b1);
    access(32'h0004_5670, 1'b0, 1'b0, 1, 0);
    fill_done(32'h0004_5670, 4, 1'b1);
    access(32'h0004_5674, 1'b1, 1'b0, 1, 1);
    access(32'h0004_5678, 1'b0, 1'b0, 1, 1);
    access(32'h0004_4670, 1'b0, 1'b0, 1, 0);
    fill_done(32'h0004_4670, 4, 1'b1);
    access(32'h0004_567C, 1'b1, 1'b0, 1, 1);
    access(32'h0004_5680, 1'b1, 1'b0, 1, 0);
    fill_done(32'h0004_5680, 4, 1'b1);
    access(32'h0004_5674, 1'b1, 1'b0, 1, 1);
    $display("test split cache done");
  endtask : t_split

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Main sequence: reset, invalidate before any enable, then the scenarios.
  initial
  begin
    step(12);
    rst_n = 1'b1;
    step(2);
    t_invalidate();
    t_bypass();
    t_data();
    t_split();
    complete_run();
  end

  // Watchdog: the scenarios need under 3000 cycles.
  initial
  begin
    #600000;
    mismatches++;
    complete_run();
  end
endmodule : testbench
